/* File: pkg/pomc_pkg.sv */
// Package with constants and types of the pluggable optic management control block.
package pomc_pkg;

    // ********************************************************
    // Two-wire device selection and memory layout
    // ********************************************************
    localparam logic [6:0] ID_PAGE_DEV = 7'h50;
    localparam logic [6:0] DIAG_PAGE_DEV = 7'h51;
    localparam int PAGE_BYTES = 256;
    localparam logic [7:0] LINK_STATUS_CONTROL_BYTE_OFFSET = 8'h6E;
    localparam int TXOFF_STATE_BIT = 7;
    localparam int SW_TXOFF_BIT = 6;
    localparam int TX_FAULT_BIT = 2;
    localparam int RECEIVE_SIGNAL_LOST_BIT = 1;
    localparam logic SW_TXOFF_RESET = 1'b0;

    // ********************************************************
    // Real-time monitor locations, most significant byte first
    // ********************************************************
    localparam int MON_W = 16;
    localparam logic [7:0] TEMP_OFFSET = 8'h60;
    localparam logic [7:0] VCC_OFFSET = 8'h62;
    localparam logic [7:0] BIAS_OFFSET = 8'h64;
    localparam logic [7:0] TXPWR_OFFSET = 8'h66;
    localparam logic [7:0] RXPWR_OFFSET = 8'h68;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int MCLK_PERIOD_NS = 10;
    localparam int LOS_TIME_NS = 1000;
    localparam int LOS_CYCLES = LOS_TIME_NS / MCLK_PERIOD_NS;
    localparam int LOS_CNT_W = $clog2(LOS_CYCLES + 1);

    // ********************************************************
    // Two-wire slave states
    // ********************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_AACK = 3'b010,
        ST_WDATA = 3'b011,
        ST_WACK = 3'b100,
        ST_RDATA = 3'b101,
        ST_RACK = 3'b110
    } pomc_tw_state_type;

endpackage

/* File: hdl/pomc_top.sv */
// Management control logic of a pluggable optical transceiver module.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Answer address 0xA0 with 256-byte identification page.
// - Answer address 0xA2 with 256-byte diagnostics page.
// - Transmit-off pin high shuts transmitter off.
// - Undriven transmit-off pin counts as high.
// - Byte 110 bit 6 is software transmit-off.
// - Byte 110 bit 7 reports transmit-off state.
// - Pin OR software bit disables transmitter.
// - Laser fault raises fault output, laser off.
// - Fault output low normally, high on fault.
// - Fault output stays latched after condition ends.
// - Toggling transmit-off or power cycle clears fault.
// - Byte 110 bit 2 mirrors transmit fault.
// - Signal loss found from received transitions.
// - Loss output high without modulation, else low.
// - Byte 110 bit 1 mirrors loss of signal.
// - Bias current and transmit power readable.
// - Supply voltage and temperature readable.
// - Received optical power readable.
module pomc_top
(
    // Clocks and reset.
    input wire logic mclk,
    input wire logic rst,
    input wire logic rx_link_clk,
    // Two-wire management bus, open drain data.
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // Transmitter control and fault, fault is open collector.
    input wire logic tx_off_pin,
    input wire logic laser_fault_det,
    output logic laser_en,
    output logic tx_fault_out,
    output logic tx_fault_oe_n,
    // Received signal.
    input wire logic rx_data,
    output logic receive_signal_lost,
    // Real-time monitor values.
    input wire logic [pomc_pkg::MON_W-1:0] temp_mon,
    input wire logic [pomc_pkg::MON_W-1:0] vcc_mon,
    input wire logic [pomc_pkg::MON_W-1:0] bias_mon,
    input wire logic [pomc_pkg::MON_W-1:0] txpwr_mon,
    input wire logic [pomc_pkg::MON_W-1:0] rxpwr_mon
);
    import pomc_pkg::*;

    // ********************************************************
    // State types
    // ********************************************************
    typedef struct packed {
        pomc_tw_state_type state;
        logic [3:0] bit_cnt;
        logic [7:0] shreg;
        logic [7:0] ptr;
        logic ptr_loaded;
        logic page;
        logic is_read;
        logic ack_ok;
        logic sda_drive;
        logic scl_m;
        logic scl_s;
        logic scl_p;
        logic sda_m;
        logic sda_s;
        logic sda_p;
        logic txo_m;
        logic txo_s;
        logic txo_p;
        logic flt_m;
        logic flt_s;
        logic act_m;
        logic act_s;
        logic act_p;
        logic sw_off;
        logic fault;
        logic los;
        logic [LOS_CNT_W-1:0] idle_cnt;
        logic laser_en;
    } pomc_state_type;

    typedef struct packed {
        logic rx_prev;
        logic act_tgl;
    } pomc_rx_state_type;

    pomc_state_type st_r;
    pomc_state_type st_nxt;
    pomc_rx_state_type rx_r;
    pomc_rx_state_type rx_nxt;

    // Both memory pages live in plain arrays beside the state.
    logic [7:0] id_mem [PAGE_BYTES];
    logic [7:0] diag_mem [PAGE_BYTES];
    logic mem_we;
    logic mem_page;
    logic [7:0] mem_addr;
    logic [7:0] mem_wdata;

    // Edge and condition terms of the synchronised bus lines, transmit-off pin and activity toggle.
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic txo_toggle;
    logic rx_activity;

    // ********************************************************
    // Read data of both pages
    // ********************************************************

    // Live status byte: transmit-off state (pin or software bit), software bit, fault and loss of signal.
    function automatic logic [7:0] status_byte(input pomc_state_type s);
        logic [7:0] b;
        b = 8'h00;
        b[TXOFF_STATE_BIT] = s.txo_s | s.sw_off;
        b[SW_TXOFF_BIT] = s.sw_off;
        b[TX_FAULT_BIT] = s.fault;
        b[RECEIVE_SIGNAL_LOST_BIT] = s.los;
        return b;
    endfunction

    // Fetches one byte of the selected page; monitors and status are live.
    function automatic logic [7:0] rd_byte(input logic pg, input logic [7:0] a,
                                           input pomc_state_type s);
        logic [7:0] b;
        b = diag_mem[a];
        if (!pg)
        begin
            b = id_mem[a];
        end
        else
        begin
            case (a)
                TEMP_OFFSET: b = temp_mon[15:8];
                TEMP_OFFSET + 8'h01: b = temp_mon[7:0];
                VCC_OFFSET: b = vcc_mon[15:8];
                VCC_OFFSET + 8'h01: b = vcc_mon[7:0];
                BIAS_OFFSET: b = bias_mon[15:8];
                BIAS_OFFSET + 8'h01: b = bias_mon[7:0];
                TXPWR_OFFSET: b = txpwr_mon[15:8];
                TXPWR_OFFSET + 8'h01: b = txpwr_mon[7:0];
                RXPWR_OFFSET: b = rxpwr_mon[15:8];
                RXPWR_OFFSET + 8'h01: b = rxpwr_mon[7:0];
                LINK_STATUS_CONTROL_BYTE_OFFSET: b = status_byte(s);
                default: b = diag_mem[a];
            endcase
        end
        return b;
    endfunction

    // ********************************************************
    // Received signal transition detector, link clock domain
    // ********************************************************

    // A toggle flips on every transition of the received data.
    always_comb
    begin
        rx_nxt = rx_r;
        rx_nxt.rx_prev = rx_data;
        if (rx_data != rx_r.rx_prev)
        begin
            rx_nxt.act_tgl = ~rx_r.act_tgl;
        end
    end

    // Registers the link side state.
    always_ff @(posedge rx_link_clk or posedge rst)
    begin
        if (rst)
        begin
            rx_r <= '0;
        end
        else
        begin
            rx_r <= rx_nxt;
        end
    end

    // ********************************************************
    // Management logic, main clock domain
    // ********************************************************

    // Edges are taken from the second flop and its delayed copy only.
    assign scl_rise = st_r.scl_s & ~st_r.scl_p;
    assign scl_fall = ~st_r.scl_s & st_r.scl_p;
    assign bus_start = st_r.scl_s & st_r.scl_p & st_r.sda_p & ~st_r.sda_s;
    assign bus_stop = st_r.scl_s & st_r.scl_p & ~st_r.sda_p & st_r.sda_s;
    assign txo_toggle = st_r.txo_s ^ st_r.txo_p;
    assign rx_activity = st_r.act_s ^ st_r.act_p;

    // Next state of the slave, transmit control, fault latch and loss timer.
    always_comb
    begin
        st_nxt = st_r;
        mem_we = 1'b0;
        mem_page = st_r.page;
        mem_addr = st_r.ptr;
        mem_wdata = st_r.shreg;

        // Synchronisers for the pins and the activity toggle.
        st_nxt.scl_m = scl_in;
        st_nxt.scl_s = st_r.scl_m;
        st_nxt.scl_p = st_r.scl_s;
        st_nxt.sda_m = sda_in;
        st_nxt.sda_s = st_r.sda_m;
        st_nxt.sda_p = st_r.sda_s;
        st_nxt.txo_m = tx_off_pin;
        st_nxt.txo_s = st_r.txo_m;
        st_nxt.txo_p = st_r.txo_s;
        st_nxt.flt_m = laser_fault_det;
        st_nxt.flt_s = st_r.flt_m;
        st_nxt.act_m = rx_r.act_tgl;
        st_nxt.act_s = st_r.act_m;
        st_nxt.act_p = st_r.act_s;

        // A pin edge clears the latch, but a live fault sets it again.
        st_nxt.fault = st_r.flt_s | (st_r.fault & ~txo_toggle);

        // Transmitter runs only with pin low, software bit clear, no fault.
        // The new fault value is used so that the laser goes dark on the same edge.
        st_nxt.laser_en = ~(st_r.txo_s | st_r.sw_off | st_nxt.fault);

        // Loss of signal after a quiet interval without transitions.
        if (rx_activity)
        begin
            st_nxt.idle_cnt = '0;
            st_nxt.los = 1'b0;
        end
        else if (st_r.idle_cnt == LOS_CNT_W'(LOS_CYCLES))
        begin
            st_nxt.los = 1'b1;
        end
        else
        begin
            st_nxt.idle_cnt = st_r.idle_cnt + LOS_CNT_W'(1);
        end

        // Two-wire slave: start and stop take priority over bit handling.
        if (bus_start)
        begin
            st_nxt.state = ST_ADDR;
            st_nxt.bit_cnt = 4'h0;
            st_nxt.sda_drive = 1'b0;
        end
        else if (bus_stop)
        begin
            st_nxt.state = ST_IDLE;
            st_nxt.sda_drive = 1'b0;
        end
        else
        begin
            unique case (st_r.state)
                ST_IDLE:
                begin
                    st_nxt.sda_drive = 1'b0;
                end
                ST_ADDR:
                begin
                    if (scl_rise)
                    begin
                        st_nxt.shreg = {st_r.shreg[6:0], st_r.sda_s};
                        st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
                    end
                    else if (scl_fall && st_r.bit_cnt == 4'h8)
                    begin
                        if (st_r.shreg[7:1] == ID_PAGE_DEV || st_r.shreg[7:1] == DIAG_PAGE_DEV)
                        begin
                            st_nxt.page = (st_r.shreg[7:1] == DIAG_PAGE_DEV);
                            st_nxt.is_read = st_r.shreg[0];
                            st_nxt.ptr_loaded = st_r.shreg[0];
                            st_nxt.sda_drive = 1'b1;
                            st_nxt.state = ST_AACK;
                        end
                        else
                        begin
                            st_nxt.state = ST_IDLE;
                        end
                    end
                end
                ST_AACK:
                begin
                    if (scl_fall)
                    begin
                        st_nxt.bit_cnt = 4'h0;
                        if (st_r.is_read)
                        begin
                            st_nxt.shreg = rd_byte(st_r.page, st_r.ptr, st_r);
                            st_nxt.sda_drive = ~st_nxt.shreg[7];
                            st_nxt.state = ST_RDATA;
                        end
                        else
                        begin
                            st_nxt.sda_drive = 1'b0;
                            st_nxt.state = ST_WDATA;
                        end
                    end
                end
                ST_WDATA:
                begin
                    if (scl_rise)
                    begin
                        st_nxt.shreg = {st_r.shreg[6:0], st_r.sda_s};
                        st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
                    end
                    else if (scl_fall && st_r.bit_cnt == 4'h8)
                    begin
                        // First byte after the address sets the pointer.
                        if (!st_r.ptr_loaded)
                        begin
                            st_nxt.ptr = st_r.shreg;
                            st_nxt.ptr_loaded = 1'b1;
                        end
                        else
                        begin
                            if (st_r.page && st_r.ptr == LINK_STATUS_CONTROL_BYTE_OFFSET)
                            begin
                                st_nxt.sw_off = st_r.shreg[SW_TXOFF_BIT];
                            end
                            else
                            begin
                                mem_we = 1'b1;
                            end
                            st_nxt.ptr = st_r.ptr + 8'h01;
                        end
                        st_nxt.sda_drive = 1'b1;
                        st_nxt.state = ST_WACK;
                    end
                end
                ST_WACK:
                begin
                    if (scl_fall)
                    begin
                        st_nxt.sda_drive = 1'b0;
                        st_nxt.bit_cnt = 4'h0;
                        st_nxt.state = ST_WDATA;
                    end
                end
                ST_RDATA:
                begin
                    if (scl_rise)
                    begin
                        st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
                    end
                    else if (scl_fall)
                    begin
                        if (st_r.bit_cnt == 4'h8)
                        begin
                            st_nxt.sda_drive = 1'b0;
                            st_nxt.ptr = st_r.ptr + 8'h01;
                            st_nxt.state = ST_RACK;
                        end
                        else
                        begin
                            st_nxt.shreg = {st_r.shreg[6:0], 1'b0};
                            st_nxt.sda_drive = ~st_r.shreg[6];
                        end
                    end
                end
                ST_RACK:
                begin
                    if (scl_rise)
                    begin
                        st_nxt.ack_ok = ~st_r.sda_s;
                        if (st_r.sda_s)
                        begin
                            st_nxt.state = ST_IDLE;
                        end
                    end
                    else if (scl_fall && st_r.ack_ok)
                    begin
                        st_nxt.bit_cnt = 4'h0;
                        st_nxt.shreg = rd_byte(st_r.page, st_r.ptr, st_r);
                        st_nxt.sda_drive = ~st_nxt.shreg[7];
                        st_nxt.state = ST_RDATA;
                    end
                end
                default:
                begin
                    st_nxt.state = ST_IDLE;
                    st_nxt.sda_drive = 1'b0;
                end
            endcase
        end
    end

    // Registers the main state; the pin synchroniser resets high.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            st_r <= '0;
            st_r.txo_m <= 1'b1;
            st_r.txo_s <= 1'b1;
            st_r.txo_p <= 1'b1;
            st_r.sw_off <= SW_TXOFF_RESET;
            st_r.los <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Stores host writes into the selected page.
    always_ff @(posedge mclk)
    begin
        if (mem_we && !mem_page)
        begin
            id_mem[mem_addr] <= mem_wdata;
        end
        if (mem_we && mem_page)
        begin
            diag_mem[mem_addr] <= mem_wdata;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************

    // Open drain lines only pull low; enable is low while pulling.
    assign sda_out = 1'b0;
    assign sda_oe_n = ~st_r.sda_drive;
    assign laser_en = st_r.laser_en;
    assign tx_fault_out = 1'b0;
    assign tx_fault_oe_n = st_r.fault;
    assign receive_signal_lost = st_r.los;

endmodule // pomc_top
`default_nettype wire

/* File: verif/pomc_checker.sv */
// Port assertions of the pluggable optic management control block.
`timescale 1ns/100ps
`default_nettype none
module pomc_checker
    import pomc_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Watched pins.
    input wire logic scl_in,
    input wire logic sda_oe_n,
    input wire logic tx_off_pin,
    input wire logic laser_fault_det,
    input wire logic laser_en,
    input wire logic tx_fault_oe_n,
    input wire logic rx_data,
    input wire logic receive_signal_lost
);
    // ********************************************************
    // Quiet time of the received data
    // ********************************************************
    logic [7:0] quiet_cnt;

    // Counts main clocks since the received data last moved.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            quiet_cnt <= 8'h00;
        else if ($changed(rx_data))
            quiet_cnt <= 8'h00;
        else if (quiet_cnt != 8'hFF)
            quiet_cnt <= quiet_cnt + 8'h01;
    end

    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);

    pin_off_a: assert property (tx_off_pin [*4] |=> !laser_en)
        else $error("laser on, pin high");
    laser_rise_a: assert property ($rose(laser_en) |-> !$past(tx_off_pin, 2))
        else $error("laser on, pin not low");
    fault_dark_a: assert property (tx_fault_oe_n |-> !laser_en)
        else $error("laser on during fault");
    fault_set_a: assert property (laser_fault_det [*5] |=> tx_fault_oe_n)
        else $error("fault not reported");
    fault_cause_a: assert property ($rose(tx_fault_oe_n) |-> $past(laser_fault_det, 3)
        || $past(laser_fault_det, 4) || $past(laser_fault_det, 5))
        else $error("fault without cause");
    fault_hold_a: assert property ((tx_fault_oe_n && $stable(tx_off_pin)) [*5]
        |=> tx_fault_oe_n)
        else $error("fault dropped");
    fault_clear_a: assert property ($fell(tx_fault_oe_n)
        |-> $past(tx_off_pin, 2) != $past(tx_off_pin, 5))
        else $error("fault cleared, no toggle");
    los_set_a: assert property (quiet_cnt > 8'(LOS_CYCLES + 40) |-> receive_signal_lost)
        else $error("loss not set");
    los_clear_a: assert property ($changed(rx_data) |-> ##[1:20] !receive_signal_lost)
        else $error("loss not cleared");
    ack_edge_a: assert property ($changed(sda_oe_n) |-> !scl_in && !$past(scl_in, 2))
        else $error("data moved, clock high");
endmodule // pomc_checker
`default_nettype wire

/* File: verif/pomc_host_model.sv */
// Host board model: two-wire management master with open-drain drive.
`timescale 1ns/100ps
`default_nettype none
module pomc_host_model
(
    // Clock and wire level.
    input wire logic mclk,
    input wire logic sda_line,
    // Open-drain drive, high means released.
    output logic scl_drv,
    output logic sda_drv
);
    // ********************************************************
    // Bus cycles
    // ********************************************************
    // Both lines rest released on the pull-ups.
    initial
    begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end

    // One bus phase of 80 ns.
    task automatic half();
        repeat (8) @(negedge mclk);
    endtask

    // Start or repeated start: data falls while the clock is high.
    task automatic start();
        sda_drv = 1'b1;
        half();
        scl_drv = 1'b1;
        half();
        sda_drv = 1'b0;
        half();
        scl_drv = 1'b0;
        half();
    endtask

    // Stop: data rises while the clock is high.
    task automatic stop();
        sda_drv = 1'b0;
        half();
        scl_drv = 1'b1;
        half();
        sda_drv = 1'b1;
        half();
    endtask

    // One bit; the wire is read at the end of clock high.
    task automatic bit_x(input logic b, output logic r);
        sda_drv = b;
        half();
        scl_drv = 1'b1;
        half();
        r = sda_line;
        scl_drv = 1'b0;
        half();
    endtask

    // Sends a byte and returns high when the device acknowledged.
    task automatic put_byte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(v[i], r);
        bit_x(1'b1, r);
        ack = ~r;
    endtask

    // Reads a byte; the last byte of a read gets no ack.
    task automatic get_byte(input logic last, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(1'b1, v[i]);
        bit_x(last, r);
    endtask

    // Writes n bytes of v, top byte first, from a pointer.
    task automatic wr(input logic [7:0] dev, ptr, input int n,
                      input logic [15:0] v, output logic ok);
        logic a;
        start();
        put_byte(dev, ok);
        if (ok)
        begin
            put_byte(ptr, a);
            for (int i = 0; i < n; i++)
                put_byte(v[15 - 8 * i -: 8], a);
        end
        stop();
    endtask

    // Reads n bytes from a pointer; the last byte lands in q[7:0].
    task automatic rd(input logic [7:0] dev, ptr, input int n,
                      output logic [79:0] q);
        logic a;
        logic [7:0] v;
        q = '0;
        start();
        put_byte(dev, a);
        put_byte(ptr, a);
        start();
        put_byte(dev | 8'h01, a);
        for (int i = 0; i < n; i++)
        begin
            get_byte(i == n - 1, v);
            q = {q[71:0], v};
        end
        stop();
    endtask
endmodule // pomc_host_model
`default_nettype wire

/* File: verif/test_pluggable_optic_mgmt_control.sv */
// Self-checking testbench of the pluggable optic management control block.
`timescale 1ns/100ps
`default_nettype none
module test_pluggable_optic_mgmt_control;
    import pomc_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic rx_link_clk = 1'b0;
    logic rx_run = 1'b1;
    logic pin_en = 1'b0;
    logic pin_val = 1'b1;
    logic scl_drv, sda_drv, sda_line, sda_out, sda_oe_n, tx_off_pin, ok;
    logic laser_fault_det, laser_en, tx_fault_out, tx_fault_oe_n, rx_data, receive_signal_lost;
    logic [15:0] mon [5];
    logic [15:0] d;
    logic [79:0] q;
    logic [7:0] p;
    int seed, failures, checks;

    // ********************************************************
    // Clocks, wires and instances
    // ********************************************************
    // Pull-ups on the data line and transmit-off pin.
    assign sda_line = sda_drv & (sda_oe_n | sda_out);
    assign tx_off_pin = pin_en ? pin_val : 1'b1;
    always #5 mclk = ~mclk;

    // Link clock of 80 ns, offset in phase, stopped outside resets and frames.
    initial
    begin
        #3;
        forever #40 if (rx_run) rx_link_clk = ~rx_link_clk;
    end

    pomc_top uut
    (
        .mclk, .rst, .rx_link_clk, .scl_in(scl_drv), .sda_in(sda_line), .sda_out, .sda_oe_n,
        .tx_off_pin, .laser_fault_det, .laser_en, .tx_fault_out, .tx_fault_oe_n, .rx_data,
        .receive_signal_lost, .temp_mon(mon[0]), .vcc_mon(mon[1]), .bias_mon(mon[2]),
        .txpwr_mon(mon[3]), .rxpwr_mon(mon[4])
    );

    pomc_host_model host
    (
        .mclk, .sda_line, .scl_drv, .sda_drv
    );

    // ********************************************************
    // Helpers
    // ********************************************************
    // Compares a seen value against the expected one.
    task automatic chk(input logic [15:0] seen, exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // Expected status byte.
    function automatic logic [7:0] st_exp(input logic pin, sw, flt, los);
        return {pin | sw, sw, 3'b000, flt, los, 1'b0};
    endfunction

    // Reads the status byte and compares it.
    task automatic status(input logic [7:0] e);
        host.rd(8'hA2, LINK_STATUS_CONTROL_BYTE_OFFSET, 1, q);
        chk(16'(q[7:0]), 16'(e));
    endtask

    // A frame of toggling received data on the link clock.
    task automatic frame(input int n);
        rx_run = 1'b1;
        repeat (n) @(negedge rx_link_clk) rx_data = ~rx_data;
        rx_run = 1'b0;
    endtask

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial
    begin
        seed = 32'hBFF1950F;
        laser_fault_det = 1'b0;
        rx_data = 1'b0;
        foreach (mon[i]) mon[i] = 16'($random(seed));
        wait_clk(10);
        rst = 1'b0;
        rx_run = 1'b0;
        wait_clk(20);
        chk(16'(laser_en), 16'h0);
        chk(16'(tx_fault_oe_n), 16'h0);
        chk(16'(tx_fault_out), 16'h0);
        pin_en = 1'b1;
        pin_val = 1'b0;
        wait_clk(10);
        chk(16'(laser_en), 16'h1);
        status(st_exp(1'b0, 1'b0, 1'b0, 1'b1));
        host.wr(8'hA4, 8'h00, 1, 16'h0, ok);
        chk(16'(ok), 16'h0);
        // Two-byte runs; the first wraps past the last byte.
        for (int k = 0; k < 3; k++)
        begin
            p = (k == 0) ? 8'hFF : 8'($random(seed)) & 8'h3F;
            d = 16'($random(seed));
            host.wr(8'hA0, p, 2, d, ok);
            chk(16'(ok), 16'h1);
            host.wr(8'hA2, p, 2, ~d, ok);
            host.rd(8'hA0, p, 2, q);
            chk(q[15:0], d);
            host.rd(8'hA2, p, 2, q);
            chk(q[15:0], ~d);
        end
        host.rd(8'hA2, TEMP_OFFSET, 10, q);
        chk(q[79:64], mon[0]);
        chk(q[63:48], mon[1]);
        chk(q[47:32], mon[2]);
        chk(q[31:16], mon[3]);
        chk(q[15:0], mon[4]);
        // Software off with every bit set; status bits stay live.
        host.wr(8'hA2, 8'h6E, 1, 16'hFF00, ok);
        wait_clk(10);
        chk(16'(laser_en), 16'h0);
        status(st_exp(1'b0, 1'b1, 1'b0, 1'b1));
        host.wr(8'hA2, 8'h6E, 1, 16'h8600, ok);
        status(st_exp(1'b0, 1'b0, 1'b0, 1'b1));
        chk(16'(laser_en), 16'h1);
        pin_val = 1'b1;
        wait_clk(10);
        chk(16'(laser_en), 16'h0);
        status(st_exp(1'b1, 1'b0, 1'b0, 1'b1));
        pin_val = 1'b0;
        // Received activity clears signal loss, silence sets it again.
        fork
            frame(250);
            begin
                wait_clk(40);
                chk(16'(receive_signal_lost), 16'h0);
                status(st_exp(1'b0, 1'b0, 1'b0, 1'b0));
            end
        join
        wait_clk(150);
        chk(16'(receive_signal_lost), 16'h1);
        // A random-length fault stays latched until the pin toggles.
        laser_fault_det = 1'b1;
        wait_clk(8 + ($random(seed) & 7));
        laser_fault_det = 1'b0;
        wait_clk(60);
        chk(16'(tx_fault_oe_n), 16'h1);
        chk(16'(laser_en), 16'h0);
        status(st_exp(1'b0, 1'b0, 1'b1, 1'b1));
        pin_val = 1'b1;
        wait_clk(10);
        pin_val = 1'b0;
        wait_clk(10);
        chk(16'(tx_fault_oe_n), 16'h0);
        chk(16'(laser_en), 16'h1);
        // A second reset clears the software bit as a power cycle would.
        host.wr(8'hA2, 8'h6E, 1, 16'h4000, ok);
        rst = 1'b1;
        rx_run = 1'b1;
        wait_clk(10);
        rst = 1'b0;
        rx_run = 1'b0;
        wait_clk(20);
        chk(16'(laser_en), 16'h1);
        status(st_exp(1'b0, 1'b0, 1'b0, 1'b1));
        tally_and_finish();
    end

    // Cuts a hang short well beyond the expected run time.
    initial
    begin
        #900000;
        failures++;
        tally_and_finish();
    end
endmodule // test_pluggable_optic_mgmt_control

bind pomc_top pomc_checker chk_i
(
    .mclk, .rst, .scl_in, .sda_oe_n, .tx_off_pin, .laser_fault_det, .laser_en, .tx_fault_oe_n,
    .rx_data, .receive_signal_lost
);
`default_nettype wire
